// file: logic/clock_divider_gen.sv
// Serial clock generator dividing the bus clock by the programmed divisor
`timescale 1ns/1ps
module clock_divider_gen (
  input wire logic pclk,
  input wire logic presetn,
  baud_if.gen      bi
);
  spi_pin_pkg::gen_state_t state;   // Idle or toggling
  spi_pin_pkg::divisor_t   divisor; // Current divisor
  logic [10:0]             half;    // Bus cycles per clock phase
  logic [10:0]             cnt;     // Cycles spent in this phase

  // Half the divisor, at least one cycle
  always_comb begin
    divisor = spi_pin_pkg::calc_divisor(bi.preselect, bi.rate_select);
    half    = divisor[11:1];
  end

  // Run or rest
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= spi_pin_pkg::gen_idle;
    end else begin
      case (state)
        spi_pin_pkg::gen_idle: if (bi.run) state <= spi_pin_pkg::gen_run;
        spi_pin_pkg::gen_run:  if (!bi.run) state <= spi_pin_pkg::gen_idle;
        default:               state <= spi_pin_pkg::gen_idle;
      endcase
    end
  end

  // Phase counter and clock level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt    <= 11'h000;
      bi.sck <= 1'b0;
      bi.toggle <= 1'b0;
    end else if (state != spi_pin_pkg::gen_run || !bi.run) begin
      // Parked at idle level, phase restarts cleanly
      cnt       <= 11'h000;
      bi.sck    <= bi.idle_high;
      bi.toggle <= 1'b0;
    end else if (cnt == half - 11'h001) begin
      cnt       <= 11'h000;
      bi.sck    <= ~bi.sck;
      bi.toggle <= 1'b1;
    end else begin
      cnt       <= cnt + 11'h001;
      bi.toggle <= 1'b0;
    end
  end
endmodule // clock_divider_gen

// file: logic/pin_direction_map.sv
// Direction and data routing of the data pins for two-pin and single-wire modes
`timescale 1ns/1ps
module pin_direction_map (
  input  wire logic enable,
  input  wire logic master,
  input  wire logic single_wire_select,
  input  wire logic single_wire_output_enable,
  input  wire logic selected,
  input  wire logic mosi_sync,
  input  wire logic miso_sync,
  output logic      mosi_oe,
  output logic      miso_oe,
  output logic      rx_src
);
  // Pin roles per mode
  always_comb begin
    mosi_oe = 1'b0;
    miso_oe = 1'b0;
    rx_src  = 1'b0;
    if (!enable) begin
      // Disabled block leaves every pin alone
      rx_src = 1'b0;
    end else if (!single_wire_select) begin
      // Two-pin mode, output enable ignored
      mosi_oe = master;
      miso_oe = !master && selected;
      rx_src  = master ? miso_sync : mosi_sync;
    end else if (master) begin
      // MISO unused, MOSI in or in/out
      mosi_oe = single_wire_output_enable;
      rx_src  = mosi_sync;
    end else begin
      // MOSI unused, MISO in or in/out
      miso_oe = single_wire_output_enable && selected;
      rx_src  = miso_sync;
    end
  end
endmodule // pin_direction_map

// file: logic/spi_pin_ctrl.sv
// Top of the pin configuration and baud generator block with its APB slave
`timescale 1ns/1ps
`include "spi_pin_defs.svh"
module spi_pin_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        xfer_active,
  input  wire logic        wait_mode,
  input  wire logic        tx_bit,
  output logic             rx_bit,
  output logic             master_mode,
  output logic             abort_idle,
  output logic             sck_edge,
  output logic             select_n,
  input  wire logic        ss_in,
  output logic             ss_out,
  output logic             ss_oe,
  input  wire logic        mosi_in,
  output logic             mosi_out,
  output logic             mosi_oe,
  input  wire logic        miso_in,
  output logic             miso_out,
  output logic             miso_oe,
  output logic             sck_out,
  output logic             sck_oe
);
  // Software-visible registers
  logic [7:0]  pin_config_control;   // Pin mode register
  logic [7:0]  clock_divider_select; // Divisor code register
  logic [7:0]  mode_control;         // Enable, master, idle level, select drive
  logic        fault_flag;           // Sticky competing-master fault

  // Named fields
  logic        fault_detect_enable;
  logic        single_wire_output_enable;
  logic        halt_in_wait;
  logic        single_wire_select;
  logic        select_output_enable;
  logic        block_enable;
  logic        idle_high;

  // APB decode
  logic        setup_phase;  // First cycle of a transfer
  logic        wr_access;    // Write taking effect this edge
  logic [7:0]  word_index;   // Register index from byte address
  logic        addr_ok;      // Address is a mapped register
  logic [7:0]  wbyte;        // Low write byte
  logic [31:0] next_rdata;   // Read value chosen in setup

  // Pin synchronisers: ss, mosi, miso
  logic [2:0]  sync1;        // First stage, read only by sync2
  logic [2:0]  sync2;
  logic [2:0]  sync3;
  logic [2:0]  pin_filt;     // Accepted levels

  // Abort and fault detection
  logic        next_abort;   // Configuration change in master
  logic        fault_event;  // Select pulled low by another master
  logic        fault_clear;  // Software write-one-to-clear
  logic        ss_is_output;
  logic        ss_is_fault_input;
  logic        rx_src;
  logic        data_oe_mosi;
  logic        data_oe_miso;

  baud_if bi ();

  assign fault_detect_enable       = pin_config_control[`BIT_FAULT_EN];
  assign single_wire_output_enable = pin_config_control[`BIT_SW_OE];
  assign halt_in_wait              = pin_config_control[`BIT_HALT_WAIT];
  assign single_wire_select        = pin_config_control[`BIT_SW_SEL];
  assign block_enable              = mode_control[`BIT_ENABLE];
  assign master_mode               = mode_control[`BIT_MASTER];
  assign idle_high                 = mode_control[`BIT_IDLE_HIGH];
  assign select_output_enable      = mode_control[`BIT_SEL_OE];

  // Bus side: no wait state; read data leave a flip-flop loaded in setup
  assign setup_phase = psel && !penable;
  assign wr_access   = psel && penable && pwrite;
  assign pready      = psel && penable;
  assign word_index  = paddr[9:2];
  assign addr_ok     = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00) &&
                       (word_index == `IDX_PIN_CONFIG || word_index == `IDX_CLOCK_DIV ||
                        word_index == `IDX_MODE_CTRL  || word_index == `IDX_STATUS);
  assign wbyte       = pwdata[7:0];

  // Read value, reserved bits read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (word_index)
      `IDX_PIN_CONFIG: next_rdata[7:0] = pin_config_control;
      `IDX_CLOCK_DIV:  next_rdata[7:0] = clock_divider_select;
      `IDX_MODE_CTRL:  next_rdata[7:0] = mode_control;
      `IDX_STATUS: begin
        next_rdata[`BIT_FAULT] = fault_flag;
        next_rdata[`BIT_BUSY]  = bi.run;
        next_rdata[`BIT_SCK]   = bi.sck;
        next_rdata[`DIV_LSB +: 12] = spi_pin_pkg::calc_divisor(
          clock_divider_select[`PRE_LSB +: 3], clock_divider_select[`RATE_LSB +: 3]);
      end
      default:         next_rdata = 32'h0000_0000;
    endcase
  end

  // Read data and error captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      prdata  <= addr_ok && !pwrite ? next_rdata : 32'h0000_0000;
      pslverr <= !addr_ok;
    end
  end

  // Pin configuration register, reserved bits dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_config_control <= `PIN_CONFIG_RESET;
    end else if (wr_access && addr_ok && word_index == `IDX_PIN_CONFIG) begin
      pin_config_control <= wbyte & `PIN_CONFIG_MASK;
    end
  end

  // Divisor code register, reserved bits dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_divider_select <= `CLOCK_DIV_RESET;
    end else if (wr_access && addr_ok && word_index == `IDX_CLOCK_DIV) begin
      clock_divider_select <= wbyte & `CLOCK_DIV_MASK;
    end
  end

  // Mode register; a fault drops the block back to slave
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_control <= `MODE_CTRL_RESET;
    end else if (fault_event) begin
      // Fault wins over a same-cycle write of the master bit
      mode_control[`BIT_MASTER] <= 1'b0;
    end else if (wr_access && addr_ok && word_index == `IDX_MODE_CTRL) begin
      mode_control <= wbyte & `MODE_CTRL_MASK;
    end
  end

  // Three-stage synchronisers; a level counts when stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1    <= 3'h7;
      sync2    <= 3'h7;
      sync3    <= 3'h7;
      pin_filt <= 3'h7;
    end else begin
      sync1    <= {ss_in, mosi_in, miso_in};
      sync2    <= sync1;
      sync3    <= sync2;
      pin_filt <= (sync2 & ~(sync2 ^ sync3)) | (pin_filt & (sync2 ^ sync3));
    end
  end

  // Select pin role per mode and enables
  always_comb begin
    ss_is_output      = block_enable && master_mode && fault_detect_enable &&
                        select_output_enable;
    ss_is_fault_input = block_enable && master_mode && fault_detect_enable &&
                        !select_output_enable;
  end

  // Slave select seen by slave logic; master never listens without detect
  assign select_n = (block_enable && !master_mode) ? pin_filt[2] : 1'b1;

  // Competing master pulling select low
  assign fault_event = ss_is_fault_input && !pin_filt[2];

  // Status write with bit set clears the fault
  assign fault_clear = wr_access && addr_ok && word_index == `IDX_STATUS && wbyte[`BIT_FAULT];

  // Sticky fault; a new fault beats a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_flag <= 1'b0;
    end else if (fault_event) begin
      fault_flag <= 1'b1;
    end else if (fault_clear) begin
      fault_flag <= 1'b0;
    end
  end

  // Configuration changes that throw a master back to idle
  always_comb begin
    next_abort = 1'b0;
    if (wr_access && addr_ok && master_mode) begin
      case (word_index)
        `IDX_PIN_CONFIG: begin
          if (wbyte[`BIT_FAULT_EN] != fault_detect_enable ||
              wbyte[`BIT_SW_SEL] != single_wire_select) begin
            next_abort = 1'b1;
          end
          if (single_wire_select && wbyte[`BIT_SW_OE] != single_wire_output_enable) begin
            next_abort = 1'b1;
          end
        end
        `IDX_CLOCK_DIV: begin
          if ((wbyte & `CLOCK_DIV_MASK) != clock_divider_select) begin
            next_abort = 1'b1;
          end
        end
        `IDX_MODE_CTRL: begin
          // Idle level, select drive and mode changes also restart
          if ((wbyte & `MODE_CTRL_MASK) != mode_control) begin
            next_abort = 1'b1;
          end
        end
        default: next_abort = 1'b0;
      endcase
    end
  end

  // Abort pulse to the shifter; a fault also forces idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abort_idle <= 1'b0;
    end else begin
      abort_idle <= next_abort || (fault_event && xfer_active);
    end
  end

  // Generator inputs; clock stops in wait only when asked
  assign bi.preselect   = clock_divider_select[`PRE_LSB +: 3];
  assign bi.rate_select = clock_divider_select[`RATE_LSB +: 3];
  assign bi.idle_high   = idle_high;
  assign bi.run         = block_enable && master_mode && xfer_active && !abort_idle &&
                          !(halt_in_wait && wait_mode);

  clock_divider_gen u_gen (
    .pclk    (pclk),
    .presetn (presetn),
    .bi      (bi)
  );

  pin_direction_map u_map (
    .enable                    (block_enable),
    .master                    (master_mode),
    .single_wire_select        (single_wire_select),
    .single_wire_output_enable (single_wire_output_enable),
    .selected                  (!pin_filt[2]),
    .mosi_sync                 (pin_filt[1]),
    .miso_sync                 (pin_filt[0]),
    .mosi_oe                   (data_oe_mosi),
    .miso_oe                   (data_oe_miso),
    .rx_src                    (rx_src)
  );

  // Pin outputs from flip-flops; enables follow the mode map
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mosi_out <= 1'b0;
      miso_out <= 1'b0;
      mosi_oe  <= 1'b0;
      miso_oe  <= 1'b0;
      ss_out   <= 1'b1;
      ss_oe    <= 1'b0;
      sck_out  <= 1'b0;
      sck_oe   <= 1'b0;
      rx_bit   <= 1'b0;
      sck_edge <= 1'b0;
    end else begin
      mosi_out <= tx_bit;
      miso_out <= tx_bit;
      mosi_oe  <= data_oe_mosi;
      miso_oe  <= data_oe_miso;
      // Select low during each transfer, high when idle
      ss_out   <= !(xfer_active && !abort_idle);
      ss_oe    <= ss_is_output;
      sck_out  <= bi.sck;
      sck_oe   <= block_enable && master_mode;
      rx_bit   <= rx_src;
      sck_edge <= bi.toggle;
    end
  end
endmodule // spi_pin_ctrl

// file: pkg/baud_if.sv
// Link between the control registers and the serial clock generator
`timescale 1ns/1ps
interface baud_if;
  logic [2:0] preselect;   // Divisor preselect code
  logic [2:0] rate_select; // Divisor exponent code
  logic       run;         // Generate clock edges
  logic       idle_high;   // Idle level of the clock
  logic       sck;         // Generated serial clock
  logic       toggle;      // Pulse on each clock edge
  modport gen (input preselect, input rate_select, input run, input idle_high, output sck, output toggle);
  modport ctl (output preselect, output rate_select, output run, output idle_high, input sck, input toggle);
endinterface

// file: pkg/spi_pin_defs.svh
// Offsets, field positions and reset values of the pin and clock control block
`ifndef SPI_PIN_DEFS_SVH
`define SPI_PIN_DEFS_SVH
`define IDX_PIN_CONFIG   8'h01
`define IDX_CLOCK_DIV    8'h02
`define IDX_MODE_CTRL    8'h08
`define IDX_STATUS       8'h09
`define PIN_CONFIG_RESET 8'h00
`define CLOCK_DIV_RESET  8'h00
`define MODE_CTRL_RESET  8'h00
`define PIN_CONFIG_MASK  8'h1b
`define CLOCK_DIV_MASK   8'h77
`define MODE_CTRL_MASK   8'h5a
`define BIT_FAULT_EN     4
`define BIT_SW_OE        3
`define BIT_HALT_WAIT    1
`define BIT_SW_SEL       0
`define PRE_LSB          4
`define RATE_LSB         0
`define BIT_ENABLE       6
`define BIT_MASTER       4
`define BIT_IDLE_HIGH    3
`define BIT_SEL_OE       1
`define BIT_FAULT        4
`define BIT_BUSY         1
`define BIT_SCK          0
`define DIV_LSB          16
`endif

// file: pkg/spi_pin_pkg.sv
// Types and the divisor arithmetic shared by the pin and clock control block
package spi_pin_pkg;
  typedef logic [11:0] divisor_t;
  typedef enum logic {gen_idle, gen_run} gen_state_t;
  // Divisor from preselect and rate select, 2 up to 2048
  function automatic divisor_t calc_divisor(input logic [2:0] pre, input logic [2:0] rate);
    logic [3:0] pre_p1;
    logic [3:0] rate_p1;
    pre_p1  = {1'b0, pre} + 4'h1;
    rate_p1 = {1'b0, rate} + 4'h1;
    return divisor_t'({8'h00, pre_p1} << rate_p1);
  endfunction
endpackage

// file: tb/spi_far_model.sv
// Far-side serial device: a slave, or a competing master
`timescale 1ns/1ps
module spi_far_model (
  input  wire logic pclk,
  input  wire logic compete,
  input  wire logic ss_out,
  input  wire logic ss_oe,
  input  wire logic mosi_out,
  input  wire logic mosi_oe,
  input  wire logic miso_out,
  input  wire logic miso_oe,
  output logic      ss_in,
  output logic      mosi_in,
  output logic      miso_in
);
  logic [7:0] pat = 8'h5a; // Far data only; no serial clock is sent in
  // Moves every cycle so a released line never keeps a stale level
  always @(posedge pclk) pat <= {pat[6:0], ~pat[7]};
  // Select has a pull-up; a competing master pulls it low
  assign ss_in   = ss_oe ? ss_out : !compete;
  assign mosi_in = mosi_oe ? mosi_out : pat[0];
  assign miso_in = miso_oe ? miso_out : pat[3];
endmodule // spi_far_model

// file: tb/spi_pin_ctrl_sva.sv
// Port checker of the pin control block
`timescale 1ns/1ps
module spi_pin_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        wait_mode,
  input wire logic        master_mode,
  input wire logic        abort_idle,
  input wire logic        ss_oe,
  input wire logic        mosi_oe,
  input wire logic        miso_oe,
  input wire logic        sck_out,
  input wire logic        sck_oe
);
  logic [7:0] cfg, div, mc;   // Shadows of written registers
  logic [7:0] cfg_d, mc_d;    // Shadows as the pin flops see them
  logic       mm_d;           // Master bit one cycle late
  logic       wr;             // Completed write
  assign wr = psel && penable && pwrite && pready;
  // Shadows keep only the accepted bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg   <= 8'h00;
      div   <= 8'h00;
      mc    <= 8'h00;
      cfg_d <= 8'h00;
      mc_d  <= 8'h00;
      mm_d  <= 1'b0;
    end else begin
      if (wr && paddr == 12'h004) cfg <= pwdata[7:0] & 8'h1b;
      if (wr && paddr == 12'h008) div <= pwdata[7:0] & 8'h77;
      if (wr && paddr == 12'h020) mc <= pwdata[7:0] & 8'h5a;
      cfg_d <= cfg;
      mc_d  <= mc;
      mm_d  <= master_mode;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Pulse may land one or two edges after the write
  sequence s_abort; ##[1:2] abort_idle; endsequence
  sequence s_halted; (cfg[1] && wait_mode) [*5]; endsequence
  property p_abort_cfg; wr && paddr == 12'h004 && master_mode
    && (pwdata[4] != cfg[4] || pwdata[0] != cfg[0]) |-> s_abort; endproperty
  a_abort_cfg: assert property (p_abort_cfg) else $error("no abort on pin mode change");
  property p_abort_oe; wr && paddr == 12'h004 && master_mode && cfg[0]
    && pwdata[3] != cfg[3] |-> s_abort; endproperty
  a_abort_oe: assert property (p_abort_oe) else $error("no abort on output enable change");
  property p_abort_div; wr && paddr == 12'h008 && master_mode
    && (pwdata[7:0] & 8'h77) != div |-> s_abort; endproperty
  a_abort_div: assert property (p_abort_div) else $error("no abort on divisor change");
  property p_wait; s_halted |-> $stable(sck_out); endproperty
  a_wait: assert property (p_wait) else $error("clock moved while halted");
  property p_ss_unused; mm_d && !cfg_d[4] |-> !ss_oe; endproperty
  a_ss_unused: assert property (p_ss_unused) else $error("select driven without detect");
  property p_ss_out; mm_d && mc_d[6] && cfg_d[4] && mc_d[1] |-> ss_oe; endproperty
  a_ss_out: assert property (p_ss_out) else $error("select not driven");
  property p_ss_slave; !mm_d |-> !ss_oe; endproperty
  a_ss_slave: assert property (p_ss_slave) else $error("slave drives select");
  property p_two_pin; mm_d && mc_d[6] && !cfg_d[0] |-> mosi_oe && !miso_oe; endproperty
  a_two_pin: assert property (p_two_pin) else $error("bad two pin directions");
  property p_sw_master; mm_d && cfg_d[0] |-> !miso_oe && mosi_oe == (mc_d[6] && cfg_d[3]); endproperty
  a_sw_master: assert property (p_sw_master) else $error("bad single wire master pins");
  property p_sw_slave; !mm_d && cfg_d[0] |-> !mosi_oe && (cfg_d[3] || !miso_oe); endproperty
  a_sw_slave: assert property (p_sw_slave) else $error("bad single wire slave pins");
  property p_sck_slave; !mm_d |-> !sck_oe; endproperty
  a_sck_slave: assert property (p_sck_slave) else $error("slave drives clock");
endmodule // spi_pin_chk
bind spi_pin_ctrl spi_pin_chk spi_pin_chk_inst (.pclk, .presetn, .psel, .penable, .pwrite, .pready,
  .paddr, .pwdata, .wait_mode, .master_mode, .abort_idle, .ss_oe, .mosi_oe, .miso_oe, .sck_out, .sck_oe);

// file: tb/testbench.sv
// Self-checking bench of the pin control and clock divider block
`timescale 1ns/1ps
module testbench;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic        pready, pslverr, rerr, seen;
  logic        xfer_active = 1'b0, wait_mode = 1'b0, tx_bit = 1'b0, compete = 1'b0;
  logic        rx_bit, master_mode, abort_idle, sck_edge, select_n, ss_in, ss_out, ss_oe;
  logic        mosi_in, mosi_out, mosi_oe, miso_in, miso_out, miso_oe, sck_out, sck_oe;
  logic [2:0]  pre, rate;
  logic [7:0]  c;
  logic [20:0] ab [6] = '{21'h100410, 21'h000412, 21'h100413, 21'h10041b, 21'h000801, 21'h100812};
  int          failures = 0, n_compared = 0, cyc = 0, h, k, i, ke;
  integer      seed = 32'hf36cc027;
  always #10 pclk = ~pclk;
  spi_pin_ctrl spi_pin_ctrl_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .xfer_active, .wait_mode, .tx_bit, .rx_bit, .master_mode, .abort_idle, .sck_edge,
    .select_n, .ss_in, .ss_out, .ss_oe, .mosi_in, .mosi_out, .mosi_oe, .miso_in, .miso_out, .miso_oe,
    .sck_out, .sck_oe);
  spi_far_model spi_far_model_inst (.pclk, .compete, .ss_out, .ss_oe, .mosi_out, .mosi_oe, .miso_out,
    .miso_oe, .ss_in, .mosi_in, .miso_in);
  // Expected divisor, worked out apart from the design
  function automatic logic [31:0] exp_div(input logic [2:0] p, input logic [2:0] r);
    return (32'(p) + 32'h1) * (32'h1 << (32'(r) + 32'h1));
  endfunction
  // Expected {mosi_oe, miso_oe} with select low in slave
  function automatic logic [1:0] exp_oe(input logic m, input logic [7:0] f);
    if (!f[0]) return m ? 2'b10 : 2'b01;
    return m ? {f[3], 1'b0} : {1'b0, f[3]};
  endfunction
  // One APB transfer, then one idle edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the cycle ceiling ends a wait for the answer
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Cycles between two clock changes
  task automatic half(output int t);
    logic s;
    int n;
    n = 0;
    t = 0;
    s = sck_out;
    while (sck_out === s && n < 3000) begin
      n++;
      @(posedge pclk);
    end
    s = sck_out;
    while (sck_out === s && t < 3000) begin
      t++;
      @(posedge pclk);
    end
  endtask
  // Clock changes seen over 20 cycles
  task automatic nchg(output int t, output int e);
    logic s;
    t = 0;
    e = 0;
    repeat (20) begin
      s = sck_out;
      @(posedge pclk);
      if (sck_out !== s) t++;
      if (sck_edge === 1'b1) e++;
    end
  endtask
  task automatic end_sim;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Cycle ceiling and abort pulse catcher
  always @(posedge pclk) begin
    cyc++;
    if (abort_idle === 1'b1) seen = 1'b1;
    if (cyc == 80000) begin
      failures++;
      end_sim;
    end
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values, reserved bits, unmapped place
    for (i = 1; i < 3; i++) begin
      apb(1'b0, 12'(4 * i), 8'h00);
      chk(rdat, 32'h0);
      apb(1'b1, 12'(4 * i), 8'hff);
      apb(1'b0, 12'(4 * i), 8'h00);
      chk(rdat, (i == 1) ? 32'h1b : 32'h77);
    end
    apb(1'b0, 12'h00c, 8'h00);
    chk({31'h0, rerr}, 32'h1);
    $display("done: registers");
    // Divisor corners, then random codes
    apb(1'b1, 12'h004, 8'h00);
    apb(1'b1, 12'h020, 8'h50);
    for (i = 0; i < 7; i++) begin
      pre  = (i == 0) ? 3'h0 : (i == 1) ? 3'h7 : 3'($random(seed));
      rate = (i == 0) ? 3'h0 : (i == 1) ? 3'h7 : 3'($random(seed));
      tx_bit <= 1'($random(seed));
      xfer_active <= 1'b0;
      apb(1'b1, 12'h008, {1'b0, pre, 1'b0, rate});
      apb(1'b0, 12'h024, 8'h00);
      chk({20'h0, rdat[27:16]}, exp_div(pre, rate));
      xfer_active <= 1'b1;
      half(h);
      chk(h, exp_div(pre, rate) / 2);
    end
    $display("done: divisor");
    // Halt in wait, then clock kept running
    apb(1'b1, 12'h008, 8'h01);
    apb(1'b1, 12'h020, 8'h58);
    for (i = 0; i < 3; i++) begin
      apb(1'b1, 12'h004, (i == 0) ? 8'h02 : 8'h00);
      wait_mode <= (i != 2);
      repeat (6) @(posedge pclk);
      nchg(k, ke);
      chk({31'h0, k == 0}, {31'h0, i == 0});
      chk(ke, k);
      if (i == 0) chk({31'h0, sck_out}, 32'h1);
    end
    $display("done: wait");
    // Changed and unchanged writes during a transfer
    for (i = 0; i < 6; i++) begin
      seen = 1'b0;
      apb(1'b1, ab[i][19:8], ab[i][7:0]);
      repeat (3) @(posedge pclk);
      chk({31'h0, seen}, {31'h0, ab[i][20]});
    end
    $display("done: abort");
    // Data pin directions, master then selected slave
    for (i = 0; i < 6; i++) begin
      c = (i % 3 == 0) ? 8'h00 : (i % 3 == 1) ? 8'h01 : 8'h09;
      compete <= (i >= 3);
      apb(1'b1, 12'h020, (i < 3) ? 8'h50 : 8'h40);
      apb(1'b1, 12'h004, c);
      repeat (8) @(posedge pclk);
      chk({30'h0, mosi_oe, miso_oe}, {30'h0, exp_oe(i < 3, c)});
      chk({31'h0, select_n}, {31'h0, i < 3});
      chk({30'h0, mosi_out, miso_out}, {30'h0, tx_bit, tx_bit});
      if (c[3]) chk({31'h0, rx_bit}, {31'h0, tx_bit});
    end
    $display("done: directions");
    // Select pin use, then a competing master
    compete <= 1'b0;
    apb(1'b1, 12'h020, 8'h52);
    for (i = 0; i < 2; i++) begin
      apb(1'b1, 12'h004, i ? 8'h10 : 8'h00);
      repeat (4) @(posedge pclk);
      chk({31'h0, ss_oe}, {31'h0, 1'(i)});
      chk({31'h0, ss_out}, 32'h0);
    end
    // Release select first, so only the far master can raise a fault
    apb(1'b1, 12'h004, 8'h00);
    apb(1'b1, 12'h020, 8'h50);
    apb(1'b1, 12'h004, 8'h10);
    repeat (8) @(posedge pclk);
    chk({31'h0, master_mode}, 32'h1);
    compete <= 1'b1;
    repeat (8) @(posedge pclk);
    chk({31'h0, master_mode}, 32'h0);
    apb(1'b0, 12'h024, 8'h00);
    chk({31'h0, rdat[4]}, 32'h1);
    chk({31'h0, ss_oe}, 32'h0);
    // Writing one clears the sticky fault
    apb(1'b1, 12'h024, 8'h10);
    apb(1'b0, 12'h024, 8'h00);
    chk({31'h0, rdat[4]}, 32'h0);
    $display("done: select");
    end_sim;
  end
endmodule // testbench
